// ---- rtl/pei_pkg.sv ----
package pei_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_GLOBAL_CTRL  = 6'h11;
    localparam logic [5:0] IDX_LINK_EVENT   = 6'h12;
    localparam logic [5:0] IDX_LINE_EVENT   = 6'h13;
    localparam logic [5:0] IDX_FALSE_CARR   = 6'h14;
    localparam logic [5:0] IDX_RX_ERROR     = 6'h15;

    // global interrupt control fields
    localparam int GC_INT_OE_BIT = 0;
    localparam int GC_INT_EN_BIT = 1;

    // line event register layout
    localparam int LINE_STAT_LSB = 8;
    localparam int LINE_STAT_MSB = 14;
    localparam int LINE_EN_LSB   = 0;
    localparam int LINE_EN_MSB   = 6;
    localparam int LINE_EVENTS   = 7;

    // link event register layout (half-full events only)
    localparam int LINK_STAT_LSB = 8;
    localparam int LINK_STAT_MSB = 9;
    localparam int LINK_EN_LSB   = 0;
    localparam int LINK_EN_MSB   = 1;
    localparam int LINK_EVENTS   = 2;

    // counter widths
    localparam int FALSE_CARR_W = 8;
    localparam int RX_ERROR_W   = 16;

    // reset values
    localparam logic [1:0]  GLOBAL_CTRL_RST = 2'h0;
    localparam logic [6:0]  LINE_EN_RST     = 7'h00;
    localparam logic [6:0]  LINE_STAT_RST   = 7'h00;
    localparam logic [1:0]  LINK_EN_RST     = 2'h0;
    localparam logic [1:0]  LINK_STAT_RST   = 2'h0;
    localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

endpackage

// ---- rtl/pei_sat_counter.sv ----
`timescale 1ns/1ps
module pei_sat_counter #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         incEn,
    input  wire logic         clrEn,
    input  wire logic [W-1:0] clrVal,
    output logic      [W-1:0] count,
    output logic              halfEvt
);

    localparam logic [W-1:0] MAX_VAL  = {W{1'b1}};
    localparam logic [W-1:0] HALF_VAL = {1'b0, {(W-1){1'b1}}};

    logic [W-1:0] count_reg;
    logic [W-1:0] baseVal;
    logic [W-1:0] count_next;

    // read clears only what was reported, so an increment in between is kept
    always_comb begin
        baseVal = clrEn ? W'(count_reg - clrVal) : count_reg;
        count_next = baseVal;
        if (incEn && baseVal != MAX_VAL) begin
            count_next = W'(baseVal + 1'b1);
        end
    end

    // count register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
    // single pulse on the step past half full
    assign halfEvt = incEn && (baseVal == HALF_VAL);

endmodule

// ---- rtl/pei_event_irq.sv ----
`timescale 1ns/1ps
// Behaviour
// - status bits latch events until read
// - enabled event raises interrupt
// - interrupt needs both global enable bits
// - status latches regardless of enables
// - bits 15 and 7 read zero
// - bits 14..9 read-only, clear on read
// - bit 8 flags pending jabber event
// - enables 6..0 gate status 14..8, reset zero
// - 8-bit false carrier count, upper zero
// - false carrier count saturates at FFh
// - count past 7Fh gives half-full event
// - reading a counter clears it
// - receive errors counted only with carrier, data valid
// - no receive error counting in loopback
// - receive error count saturates at FFFFh
// - count past 7FFFh gives half-full event
// - half-full events latch in link register 9,8
// - pin is interrupt out or power-down in
module pei_event_irq #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // line events, one-cycle pulses
    input  wire logic              anErrorEvt,
    input  wire logic              pageRecvEvt,
    input  wire logic              loopFifoErrEvt,
    input  wire logic              crossoverEvt,
    input  wire logic              sleepEvt,
    input  wire logic              polarityEvt,
    input  wire logic              jabberEvt,
    // counter sources
    input  wire logic              falseCarrierEvt,
    input  wire logic              rxCarrierValid,
    input  wire logic              rxDataValid,
    input  wire logic              rxSymbolErrEvt,
    input  wire logic              miiLoopback,
    // shared interrupt / power-down pin
    input  wire logic              intPwdnIn,
    output logic                   intPwdnOut,
    output logic                   intPwdnOeB,
    output logic                   powerDownReq
);

    logic [1:0]                       globalCtrl_reg;
    logic [pei_pkg::LINE_EVENTS-1:0]  lineEn_reg;
    logic [pei_pkg::LINE_EVENTS-1:0]  lineStat_reg;
    logic [pei_pkg::LINE_EVENTS-1:0]  lineStat_next;
    logic [pei_pkg::LINK_EVENTS-1:0]  linkEn_reg;
    logic [pei_pkg::LINK_EVENTS-1:0]  linkStat_reg;
    logic [pei_pkg::LINK_EVENTS-1:0]  linkStat_next;
    logic [31:0]                      prdata_reg;
    logic [31:0]                      readVal;
    logic [5:0]                       rdIdx_reg;
    logic                             irq_reg;
    logic                             irq_next;
    logic                             power_down_input_reg;
    logic [pei_pkg::LINE_EVENTS-1:0]  lineEvents;
    logic [pei_pkg::LINK_EVENTS-1:0]  linkEvents;
    logic [pei_pkg::FALSE_CARR_W-1:0] fcCount;
    logic [pei_pkg::RX_ERROR_W-1:0]   reCount;
    logic                             fcHalfEvt;
    logic                             reHalfEvt;
    logic                             reInc;
    logic                             setupRd;
    logic                             accessRd;
    logic                             accessWr;
    logic                             mapped;
    logic [5:0]                       idx;
    logic                             clrLine;
    logic                             clrLink;
    logic                             clrFc;
    logic                             clrRe;
    logic                             setupPhase;
    logic                             accessPhase;
    logic                             wrGlobal;
    logic                             wrLink;
    logic                             wrLine;
    logic                             fcInc;
    logic                             intOutEn;
    logic                             evtIntEn;
    logic                             linePending;
    logic                             linkPending;
    logic [pei_pkg::LINE_EVENTS-1:0]  lineReported;
    logic [pei_pkg::LINK_EVENTS-1:0]  linkReported;
    logic [pei_pkg::FALSE_CARR_W-1:0] fcReported;
    logic [pei_pkg::RX_ERROR_W-1:0]   reReported;

    // word index and mapped decode
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [5:0] i;
        i = a[7:2];
        is_mapped = (a[1:0] == 2'h0) && (i >= pei_pkg::IDX_GLOBAL_CTRL)
                    && (i <= pei_pkg::IDX_RX_ERROR);
        if (ADDR_W > 8) begin
            is_mapped = is_mapped && ((a >> 8) == '0);
        end
    endfunction

    // strobe qualified by a register index, shared by write and clear decode
    function automatic logic hit(input logic strobe, input logic [5:0] at,
                                 input logic [5:0] which);
        hit = strobe && (at == which);
    endfunction

    // any status bit whose enable is also set
    function automatic logic any_pending(input logic [pei_pkg::LINE_EVENTS-1:0] stat,
                                         input logic [pei_pkg::LINE_EVENTS-1:0] en);
        any_pending = |(stat & en);
    endfunction

    assign idx    = paddr[7:2];
    assign mapped = is_mapped(paddr);

    // apb phase decode
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign setupRd     = setupPhase && !pwrite && mapped;
    assign accessRd    = accessPhase && !pwrite && mapped;
    assign accessWr    = accessPhase && pwrite && mapped;

    // zero wait state: data was captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = accessPhase && !mapped;
    assign prdata  = prdata_reg;

    // event vector, bit 6 = negotiation error down to bit 0 = jabber
    assign lineEvents = {anErrorEvt, pageRecvEvt, loopFifoErrEvt, crossoverEvt,
                         sleepEvt, polarityEvt, jabberEvt};
    assign linkEvents = {fcHalfEvt, reHalfEvt};

    // receive error qualification
    assign reInc = rxSymbolErrEvt && rxCarrierValid && rxDataValid
                   && !miiLoopback;

    // every false carrier event counts
    assign fcInc = falseCarrierEvt;

    // clear strobes on completion of a read of the same register
    assign clrLine = hit(accessRd, rdIdx_reg, pei_pkg::IDX_LINE_EVENT);
    assign clrLink = hit(accessRd, rdIdx_reg, pei_pkg::IDX_LINK_EVENT);
    assign clrFc   = hit(accessRd, rdIdx_reg, pei_pkg::IDX_FALSE_CARR);
    assign clrRe   = hit(accessRd, rdIdx_reg, pei_pkg::IDX_RX_ERROR);

    // what the read in flight reported; a read clears only that much
    assign lineReported = prdata_reg[pei_pkg::LINE_STAT_MSB:pei_pkg::LINE_STAT_LSB];
    assign linkReported = prdata_reg[pei_pkg::LINK_STAT_MSB:pei_pkg::LINK_STAT_LSB];
    assign fcReported   = prdata_reg[pei_pkg::FALSE_CARR_W-1:0];
    assign reReported   = prdata_reg[pei_pkg::RX_ERROR_W-1:0];

    // write strobes; status and counter registers take no writes
    assign wrGlobal = hit(accessWr, idx, pei_pkg::IDX_GLOBAL_CTRL);
    assign wrLink   = hit(accessWr, idx, pei_pkg::IDX_LINK_EVENT);
    assign wrLine   = hit(accessWr, idx, pei_pkg::IDX_LINE_EVENT);

    // false carrier counter
    pei_sat_counter #(
        .W (pei_pkg::FALSE_CARR_W)
    ) u_fc_counter (
        .clk     (clk),
        .rst_b   (rst_b),
        .incEn   (fcInc),
        .clrEn   (clrFc),
        .clrVal  (fcReported),
        .count   (fcCount),
        .halfEvt (fcHalfEvt)
    );

    // receive error counter
    pei_sat_counter #(
        .W (pei_pkg::RX_ERROR_W)
    ) u_re_counter (
        .clk     (clk),
        .rst_b   (rst_b),
        .incEn   (reInc),
        .clrEn   (clrRe),
        .clrVal  (reReported),
        .count   (reCount),
        .halfEvt (reHalfEvt)
    );

    // read mux; unlisted bits read zero
    always_comb begin
        readVal = '0;
        unique case (idx)
            pei_pkg::IDX_GLOBAL_CTRL: begin
                readVal[1:0] = globalCtrl_reg;
            end
            pei_pkg::IDX_LINK_EVENT: begin
                readVal[pei_pkg::LINK_STAT_MSB:pei_pkg::LINK_STAT_LSB] = linkStat_reg;
                readVal[pei_pkg::LINK_EN_MSB:pei_pkg::LINK_EN_LSB]     = linkEn_reg;
            end
            pei_pkg::IDX_LINE_EVENT: begin
                // bits 15 and 7 stay zero
                readVal[pei_pkg::LINE_STAT_MSB:pei_pkg::LINE_STAT_LSB] = lineStat_reg;
                readVal[pei_pkg::LINE_EN_MSB:pei_pkg::LINE_EN_LSB]     = lineEn_reg;
            end
            pei_pkg::IDX_FALSE_CARR: begin
                readVal[pei_pkg::FALSE_CARR_W-1:0] = fcCount;
            end
            pei_pkg::IDX_RX_ERROR: begin
                readVal[pei_pkg::RX_ERROR_W-1:0] = reCount;
            end
            default: begin
                readVal = '0;
            end
        endcase
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_reg <= pei_pkg::RDATA_RST;
        end else if (setupRd) begin
            prdata_reg <= readVal;
        end
    end

    // index of the read in flight; dropped after its access cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdIdx_reg <= 6'h00;
        end else if (setupRd) begin
            rdIdx_reg <= idx;
        end else if (setupPhase) begin
            rdIdx_reg <= 6'h00; // a write or unmapped setup clears nothing
        end else if (accessPhase) begin
            rdIdx_reg <= 6'h00; // a stale index never clears twice
        end
    end

    // line status: set wins, read clears only the bits reported
    always_comb begin
        lineStat_next = lineStat_reg;
        if (clrLine) begin
            lineStat_next = lineStat_reg &
                ~lineReported;
        end
        lineStat_next = lineStat_next | lineEvents;
    end

    // link status half-full bits, same policy
    always_comb begin
        linkStat_next = linkStat_reg;
        if (clrLink) begin
            linkStat_next = linkStat_reg &
                ~linkReported;
        end
        linkStat_next = linkStat_next | linkEvents;
    end

    // line status register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lineStat_reg <= pei_pkg::LINE_STAT_RST;
        end else begin
            lineStat_reg <= lineStat_next;
        end
    end

    // link status register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            linkStat_reg <= pei_pkg::LINK_STAT_RST;
        end else begin
            linkStat_reg <= linkStat_next;
        end
    end

    // global control: event interrupt enable and pin output enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            globalCtrl_reg <= pei_pkg::GLOBAL_CTRL_RST;
        end else if (wrGlobal) begin
            globalCtrl_reg <= pwdata[1:0];
        end
    end

    // link event enables
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            linkEn_reg <= pei_pkg::LINK_EN_RST;
        end else if (wrLink) begin
            linkEn_reg <= pwdata[pei_pkg::LINK_EN_MSB:pei_pkg::LINK_EN_LSB];
        end
    end

    // line event enables; reserved bit 7 and status bits ignore writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lineEn_reg <= pei_pkg::LINE_EN_RST;
        end else if (wrLine) begin
            lineEn_reg <= pwdata[pei_pkg::LINE_EN_MSB:pei_pkg::LINE_EN_LSB];
        end
    end

    // global enable bits by name
    assign intOutEn = globalCtrl_reg[pei_pkg::GC_INT_OE_BIT];
    assign evtIntEn = globalCtrl_reg[pei_pkg::GC_INT_EN_BIT];

    // enabled pending status per register
    assign linePending = any_pending(lineStat_reg, lineEn_reg);
    assign linkPending = any_pending({5'h00, linkStat_reg}, {5'h00, linkEn_reg});

    // interrupt level from enabled pending status, both global bits needed
    always_comb begin
        irq_next = evtIntEn && intOutEn
                   && (linePending || linkPending);
    end

    // interrupt register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // power-down request while the pin is an input
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_down_input_reg <= 1'b0;
        end else begin
            power_down_input_reg <= !intOutEn && !intPwdnIn;
        end
    end

    // shared pin: driven low for interrupt when output enabled
    assign intPwdnOeB   = !intOutEn;
    assign intPwdnOut   = !irq_reg;
    assign powerDownReq = power_down_input_reg;

endmodule

// ---- test/pei_event_irq_asserts.sv ----
`timescale 1ns/1ps
module pei_event_irq_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              intPwdnIn,
    input wire logic              intPwdnOut,
    input wire logic              intPwdnOeB,
    input wire logic              powerDownReq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // apb access phase, optionally at one address
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_at(a);
        psel && penable && paddr == a;
    endsequence
    chk_ready_high: assert property (s_acc |-> pready) else $error("pready low in access");
    chk_err_unmapped: assert property (s_at(8'h40) |-> pslverr) else $error("no slave error");
    chk_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    chk_line_rsvd: assert property (
        s_at(8'h4C) |-> pwrite || (prdata[31:16] == 16'h0000 && !prdata[15] && !prdata[7]))
        else $error("reserved bits set");
    chk_fc_upper: assert property (s_at(8'h50) |-> pwrite || prdata[31:8] == 24'h000000)
        else $error("false carrier upper bits set");
    chk_rx_upper: assert property (s_at(8'h54) |-> pwrite || prdata[31:16] == 16'h0000)
        else $error("rx error upper bits set");
    chk_irq_gated: assert property ($past(intPwdnOeB) |-> intPwdnOut)
        else $error("interrupt without output enable");
    chk_power_down_input_follow: assert property (intPwdnOeB |=> powerDownReq == !$past(intPwdnIn))
        else $error("power-down does not follow pin");
    chk_power_down_input_quiet: assert property (!intPwdnOeB |=> !powerDownReq)
        else $error("power-down while pin is output");
endmodule

bind pei_event_irq pei_event_irq_chk #(.ADDR_W(ADDR_W)) u_pei_event_irq_chk (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .intPwdnIn, .intPwdnOut, .intPwdnOeB, .powerDownReq);

// ---- test/pei_pin_model.sv ----
`timescale 1ns/1ps
module pei_pin_model (
    input  wire logic pinOut,
    input  wire logic pinOeB,
    input  wire logic pullDown,
    output logic      pinLevel
);
    // block drives when enabled, else host pull-down or board pull-up
    assign pinLevel = !pinOeB ? pinOut : !pullDown;
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        lastErr;
    logic [6:0]  evt = 7'h00;
    logic        fcEvt = 1'b0;
    logic        carrier = 1'b1;
    logic        dataValid = 1'b1;
    logic        symErr = 1'b0;
    logic        loopback = 1'b0;
    logic        pullDown = 1'b0;
    logic        pinIn;
    logic        pinOut;
    logic        pinOeB;
    logic        pwdnReq;
    int          n_fail = 0;
    int          samples_checked = 0;
    // clock and parts
    always #12.5 clk = ~clk;
    pei_event_irq u_pei_event_irq (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .anErrorEvt(evt[6]), .pageRecvEvt(evt[5]),
        .loopFifoErrEvt(evt[4]), .crossoverEvt(evt[3]), .sleepEvt(evt[2]),
        .polarityEvt(evt[1]), .jabberEvt(evt[0]), .falseCarrierEvt(fcEvt),
        .rxCarrierValid(carrier), .rxDataValid(dataValid), .rxSymbolErrEvt(symErr),
        .miiLoopback(loopback), .intPwdnIn(pinIn), .intPwdnOut(pinOut),
        .intPwdnOeB(pinOeB), .powerDownReq(pwdnReq));
    pei_pin_model u_pei_pin_model (.pinOut(pinOut), .pinOeB(pinOeB), .pullDown(pullDown),
        .pinLevel(pinIn));
    // verdict and compare
    task automatic finish_test;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd      = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask
    // stimulus pulses and pin sampling
    task automatic pulse(input logic [6:0] v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= 7'h00;
    endtask
    task automatic count(input int n, input logic fc);
        @(posedge clk);
        fcEvt  <= fc;
        symErr <= !fc;
        repeat (n) @(posedge clk);
        fcEvt  <= 1'b0;
        symErr <= 1'b0;
    endtask
    task automatic pin(input logic [31:0] exp, input logic [31:0] seenSel);
        repeat (2) @(posedge clk);
        #1;
        check(seenSel ? {31'h0, pwdnReq} : {31'h0, pinIn}, exp);
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(8'h4C, 32'h0000_0000);
        apb(1'b1, 8'h4C, 32'hFFFF_FFFF);
        rdchk(8'h4C, 32'h0000_007F);
        for (int i = 0; i < 7; i++) pulse(7'h01 << i);
        rdchk(8'h4C, 32'h0000_7F7F);
        rdchk(8'h4C, 32'h0000_007F);
        pulse(7'h01);
        apb(1'b1, 8'h44, 32'h0000_0001);
        pin(32'h1, 32'h0);
        apb(1'b1, 8'h44, 32'h0000_0003);
        pin(32'h0, 32'h0);
        rdchk(8'h4C, 32'h0000_017F);
        pin(32'h1, 32'h0);
        apb(1'b1, 8'h4C, 32'h0000_0000);
        pulse(7'h04);
        pin(32'h1, 32'h0);
        rdchk(8'h4C, 32'h0000_0400);
        apb(1'b1, 8'h44, 32'h0000_0000);
        pullDown <= 1'b1;
        pin(32'h1, 32'h1);
        pullDown <= 1'b0;
        count(32'h80, 1'b1);
        rdchk(8'h48, 32'h0000_0200);
        rdchk(8'h50, 32'h0000_0080);
        count(32'h100, 1'b1);
        rdchk(8'h50, 32'h0000_00FF);
        rdchk(8'h50, 32'h0000_0000);
        loopback <= 1'b1;
        count(32'h10, 1'b0);
        rdchk(8'h54, 32'h0000_0000);
        loopback  <= 1'b0;
        dataValid <= 1'b0;
        count(32'h10, 1'b0);
        rdchk(8'h54, 32'h0000_0000);
        carrier   <= 1'b0;
        dataValid <= 1'b1;
        count(32'h10, 1'b0);
        rdchk(8'h54, 32'h0000_0000);
        carrier   <= 1'b1;
        count(32'h10000, 1'b0);
        rdchk(8'h54, 32'h0000_FFFF);
        rdchk(8'h48, 32'h0000_0300);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check({31'h0, lastErr}, 32'h1);
        finish_test();
    end
    // watchdog
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule
